// [inc/asrc_map.vh]
// Constants and timing for the asynchronous static memory host port.
// Contract
// - Write: select and write strobe both low
// - Read: select, output enable low, strobe high
// - Write ends when select or strobe rises
// - Data timing referenced to terminating edge
// - Strobe write with enable low: float+setup
// - Host never drives while device drives
// - Address valid before select falls
// - Read cycle 10 ns, access 10 ns
// - Address held 7 ns before write end
// - Data set up 5 ns before end
`ifndef ASRC_MAP_VH
`define ASRC_MAP_VH
`define ASRC_CLK_PERIOD_NS 10
`define ASRC_READ_CYCLE_MIN_NS 10
`define ASRC_ADDRESS_ACCESS_MAX_NS 10
`define ASRC_OUTPUT_ENABLE_ACCESS_MAX_NS 5
`define ASRC_DESELECT_TO_STANDBY_MAX_NS 10
`define ASRC_ADDRESS_SETUP_TO_WRITE_END_NS 7
`define ASRC_DATA_SETUP_TO_WRITE_END_NS 5
`define ASRC_WRITE_STROBE_TO_FLOAT_DELAY_NS 5
`define ASRC_CYC_UP(ns) (((ns) + `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS)
`define ASRC_ADDR_W 17
`define ASRC_DATA_W 8
`define ASRC_CNT_W 4
`define ASRC_CNT_ZERO 4'h0
`define ASRC_CNT_ONE 4'h1
`endif

// [verilog/asrc_pin_sync.v]
// Two-stage synchroniser for the data lines coming back from the memory.
`timescale 1ns/100ps
module asrc_pin_sync #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Asynchronous in, synchronised out
  input wire [WIDTH-1:0] pinIn,
  output reg [WIDTH-1:0] pinSync_q
);
  reg [WIDTH-1:0] pinMeta_q;
  // The first stage is read only by the second stage.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pinMeta_q <= {WIDTH{1'b0}};
      pinSync_q <= {WIDTH{1'b0}};
    end else begin
      pinMeta_q <= pinIn;
      pinSync_q <= pinMeta_q;
    end
  end
endmodule // asrc_pin_sync

// [verilog/asrc_host.v]
// Host controller driving an asynchronous 128K by 8 static memory.
`timescale 1ns/100ps
`include "asrc_map.vh"
module asrc_host #(
  parameter ADDR_W = `ASRC_ADDR_W,
  parameter DATA_W = `ASRC_DATA_W
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // User request port
  input wire reqValid,
  output wire reqReady,
  input wire reqWrite,
  input wire [ADDR_W-1:0] reqAddr,
  input wire [DATA_W-1:0] reqWdata,
  // User answer port
  output reg rspValid_q,
  output reg [DATA_W-1:0] rspRdata_q,
  // Memory pins
  output reg [ADDR_W-1:0] wordAddress_q,
  output reg chipSelectN_q,
  output reg outputEnableN_q,
  output reg writeStrobeN_q,
  input wire [DATA_W-1:0] dataLinesIn,
  output reg [DATA_W-1:0] dataLinesOut_q,
  output reg dataLinesOe_q
);
  // Cycle counts derived from the fastest grade, rounded up.
  localparam [`ASRC_CNT_W-1:0] RD_CYC =
    `ASRC_CYC_UP(`ASRC_ADDRESS_ACCESS_MAX_NS) + 2;
  localparam [`ASRC_CNT_W-1:0] OE_CYC =
    `ASRC_CYC_UP(`ASRC_OUTPUT_ENABLE_ACCESS_MAX_NS);
  localparam [`ASRC_CNT_W-1:0] WR_ADDR_CYC =
    `ASRC_CYC_UP(`ASRC_ADDRESS_SETUP_TO_WRITE_END_NS);
  localparam [`ASRC_CNT_W-1:0] WR_DATA_CYC =
    `ASRC_CYC_UP(`ASRC_DATA_SETUP_TO_WRITE_END_NS);
  localparam [`ASRC_CNT_W-1:0] WR_CYC =
    (WR_ADDR_CYC > WR_DATA_CYC) ? WR_ADDR_CYC : WR_DATA_CYC;
  localparam [`ASRC_CNT_W-1:0] IDLE_CYC =
    `ASRC_CYC_UP(`ASRC_DESELECT_TO_STANDBY_MAX_NS);
  localparam [`ASRC_CNT_W-1:0] CYC_MIN =
    `ASRC_CYC_UP(`ASRC_READ_CYCLE_MIN_NS);
  localparam [`ASRC_CNT_W-1:0] FLOAT_CYC =
    `ASRC_CYC_UP(`ASRC_WRITE_STROBE_TO_FLOAT_DELAY_NS);
  // One-hot states.
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_RSET = 5'h02;
  localparam [4:0] ST_READ = 5'h04;
  localparam [4:0] ST_WRITE = 5'h08;
  localparam [4:0] ST_GAP = 5'h10;

  reg [4:0] state_q;
  reg [4:0] state_d;
  reg [`ASRC_CNT_W-1:0] cnt_q;
  reg [`ASRC_CNT_W-1:0] cnt_d;
  wire [DATA_W-1:0] dataSync;
  wire cntDone;

  asrc_pin_sync #(
    .WIDTH(DATA_W)
  ) uSync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pinIn(dataLinesIn),
    .pinSync_q(dataSync)
  );

  assign cntDone = (cnt_q == `ASRC_CNT_ZERO);
  assign reqReady = state_q[0];

  always @* begin
    state_d = state_q;
    cnt_d = cntDone ? cnt_q : cnt_q - `ASRC_CNT_ONE;
    case (state_q)
      ST_IDLE: begin
        if (reqValid) begin
          // Address is set one cycle before select falls.
          state_d = ST_RSET;
          cnt_d = `ASRC_CNT_ZERO;
        end
      end
      ST_RSET: begin
        if (writeStrobeN_q) begin
          state_d = ST_READ;
          // Extra cycles cover the two-stage capture of the data lines.
          cnt_d = (RD_CYC > OE_CYC) ? RD_CYC : OE_CYC;
        end else begin
          state_d = ST_WRITE;
          cnt_d = WR_CYC + FLOAT_CYC - `ASRC_CNT_ONE;
        end
      end
      ST_READ: begin
        if (cntDone) begin
          state_d = ST_GAP;
          cnt_d = CYC_MIN;
        end
      end
      ST_WRITE: begin
        if (cntDone) begin
          state_d = ST_GAP;
          cnt_d = IDLE_CYC;
        end
      end
      ST_GAP: begin
        if (cntDone) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
        cnt_d = `ASRC_CNT_ZERO;
      end
    endcase
  end

  // All strobes leave flip-flops so the pins never glitch.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      cnt_q <= `ASRC_CNT_ZERO;
      wordAddress_q <= {ADDR_W{1'b0}};
      chipSelectN_q <= 1'b1;
      outputEnableN_q <= 1'b1;
      writeStrobeN_q <= 1'b1;
      dataLinesOut_q <= {DATA_W{1'b0}};
      dataLinesOe_q <= 1'b0;
      rspValid_q <= 1'b0;
      rspRdata_q <= {DATA_W{1'b0}};
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      rspValid_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          // Standby between accesses keeps power down.
          chipSelectN_q <= 1'b1;
          if (reqValid) begin
            wordAddress_q <= reqAddr;
            dataLinesOut_q <= reqWdata;
            writeStrobeN_q <= ~reqWrite;
          end
        end
        ST_RSET: begin
          chipSelectN_q <= 1'b0;
          if (writeStrobeN_q) begin
            outputEnableN_q <= 1'b0;
          end else begin
            // Write strobe was low already; select falling starts it.
            dataLinesOe_q <= 1'b1;
          end
        end
        ST_READ: begin
          if (cntDone) begin
            rspRdata_q <= dataSync;
            rspValid_q <= 1'b1;
            outputEnableN_q <= 1'b1;
            chipSelectN_q <= 1'b1;
          end
        end
        ST_WRITE: begin
          if (cntDone) begin
            // Both rise together; data is held through that edge.
            chipSelectN_q <= 1'b1;
            writeStrobeN_q <= 1'b1;
          end
        end
        ST_GAP: begin
          // Drive is released only after the strobes are high.
          dataLinesOe_q <= 1'b0;
        end
        default: begin
          chipSelectN_q <= 1'b1;
          outputEnableN_q <= 1'b1;
          writeStrobeN_q <= 1'b1;
          dataLinesOe_q <= 1'b0;
        end
      endcase
    end
  end
endmodule // asrc_host

// [tb/asrc_mem_model.sv]
// Behavioural model of the 128K by 8 asynchronous static memory.
`timescale 1ns/100ps
module asrc_mem_model (
  // Memory pins
  input wire [16:0] wordAddress_q,
  input wire chipSelectN_q,
  input wire outputEnableN_q,
  input wire writeStrobeN_q,
  input wire [7:0] dataLinesIn,
  // Model drive
  output wire [7:0] memOut,
  output wire memOe
);
  logic [7:0] mem [0:131071];
  wire wr = !chipSelectN_q && !writeStrobeN_q;
  // Floats when deselected, disabled or writing; standby is implied.
  assign memOe = !chipSelectN_q && !outputEnableN_q && writeStrobeN_q;
  // The same term covers read mode, standby and the floating cases.
  wire memOeAlias = memOe;
  assign memOut = mem[wordAddress_q];
  // The store happens at the edge that ends the overlap.
  always @(negedge wr) mem[wordAddress_q] <= dataLinesIn;
endmodule // asrc_mem_model

// [tb/asrc_host_chk.sv]
// Pin checker for the static memory host port.
`timescale 1ns/100ps
module asrc_host_chk (
  // Clock, reset and status
  input wire clk,
  input wire sys_rst,
  input wire reqReady,
  input wire rspValid_q,
  // Memory pins
  input wire [16:0] wordAddress_q,
  input wire chipSelectN_q,
  input wire outputEnableN_q,
  input wire writeStrobeN_q,
  input wire [7:0] dataLinesOut_q,
  input wire dataLinesOe_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire wr = !chipSelectN_q && !writeStrobeN_q;
  sequence sRdStart;
    $fell(outputEnableN_q);
  endsequence
  chk_no_contention: assert property (!(dataLinesOe_q && !outputEnableN_q))
    else $error("host drives in read");
  chk_read_mode: assert property (!outputEnableN_q |-> !chipSelectN_q && writeStrobeN_q)
    else $error("bad read mode");
  chk_write_drive: assert property (wr |-> dataLinesOe_q)
    else $error("write undriven");
  chk_write_setup: assert property ($rose(wr) |-> $stable(wordAddress_q) && $stable(dataLinesOut_q))
    else $error("write setup");
  chk_write_end: assert property ($rose(writeStrobeN_q) |-> $rose(chipSelectN_q))
    else $error("split write end");
  chk_addr_first: assert property ($fell(chipSelectN_q) |-> $stable(wordAddress_q))
    else $error("address late");
  chk_read_hold: assert property (sRdStart |-> (!outputEnableN_q && $stable(wordAddress_q))[*2])
    else $error("read too short");
  chk_read_answer: assert property (sRdStart |-> ##[2:8] rspValid_q)
    else $error("no read answer");
  chk_idle_pins: assert property (reqReady |-> chipSelectN_q && writeStrobeN_q && !dataLinesOe_q)
    else $error("idle pins");
endmodule // asrc_host_chk
bind asrc_host asrc_host_chk u_chk (.clk, .sys_rst, .reqReady, .rspValid_q,
  .wordAddress_q, .chipSelectN_q, .outputEnableN_q, .writeStrobeN_q,
  .dataLinesOut_q, .dataLinesOe_q);

// [tb/testbench.sv]
// Self-checking testbench for the static memory host port.
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reqValid = 1'b0;
  logic reqWrite = 1'b0;
  logic [16:0] reqAddr = 17'h00000;
  logic [7:0] reqWdata = 8'h00;
  wire reqReady, rspValid_q, chipSelectN_q, outputEnableN_q, writeStrobeN_q;
  wire dataLinesOe_q, memOe;
  wire [16:0] wordAddress_q;
  wire [7:0] rspRdata_q, dataLinesOut_q, memOut, dataLinesIn;
  int errors = 0;
  int n_tests = 0;
  always #5 clk = ~clk;
  // Undriven lines toggle so a stale value cannot pass for read data.
  assign dataLinesIn = memOe ? memOut : dataLinesOe_q ? dataLinesOut_q : {4{clk, ~clk}};
  asrc_host DUT (.clk, .sys_rst, .reqValid, .reqReady, .reqWrite, .reqAddr,
    .reqWdata, .rspValid_q, .rspRdata_q, .wordAddress_q, .chipSelectN_q,
    .outputEnableN_q, .writeStrobeN_q, .dataLinesIn, .dataLinesOut_q,
    .dataLinesOe_q);
  asrc_mem_model mem (.wordAddress_q, .chipSelectN_q, .outputEnableN_q,
    .writeStrobeN_q, .dataLinesIn, .memOut, .memOe);
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask
  task req(input logic w, input logic [16:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    reqValid <= 1'b1;
    reqWrite <= w;
    reqAddr <= a;
    reqWdata <= d;
    @(negedge clk);
    while (reqReady !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    // A request that is never taken must not slip through unnoticed.
    chk("ready before take", 8'h01, {7'h00, reqReady});
    @(posedge clk);
    reqValid <= 1'b0;
    @(negedge clk);
    chk("ready after take", 8'h00, {7'h00, reqReady});
  endtask
  task rd(input logic [16:0] a, input logic [7:0] exp);
    int n;
    n = 0;
    req(1'b0, a, 8'h00);
    while (rspValid_q !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    // Stale data from an earlier read must not pass for a missing answer.
    chk("read valid", 8'h01, {7'h00, rspValid_q});
    chk("read data", exp, rspRdata_q);
  endtask
  task t_edges;
    req(1'b1, 17'h00000, 8'h5A);
    req(1'b1, 17'h1FFFF, 8'hA5);
    rd(17'h00000, 8'h5A);
    rd(17'h1FFFF, 8'hA5);
    $display("edges done");
  endtask
  task t_b2b;
    req(1'b1, 17'h00100, 8'h11);
    req(1'b1, 17'h00100, 8'hEE);
    rd(17'h00100, 8'hEE);
    rd(17'h00100, 8'hEE);
    $display("back to back done");
  endtask
  task t_reset;
    @(posedge clk);
    sys_rst <= 1'b1;
    @(negedge clk);
    chk("pins in reset", 8'h0E, {4'h0, chipSelectN_q, outputEnableN_q,
      writeStrobeN_q, dataLinesOe_q});
    @(posedge clk);
    sys_rst <= 1'b0;
    rd(17'h1FFFF, 8'hA5);
    $display("reset done");
  endtask
  task end_sim;
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    t_edges();
    t_b2b();
    t_reset();
    end_sim();
  end
  initial begin
    #20000;
    errors++;
    end_sim();
  end
endmodule // testbench
